// File: bench/regs_properties.sv
`timescale 1ns/1ps
module regs_properties (
  input wire logic       clock_in,
  input wire logic       reset_in,
  input wire logic       spi_cs_n_in,
  input wire logic [3:0] bus_fault_code_in,
  input wire logic       en_ctrl_in,
  input wire logic       en_out,
  input wire logic       sw_dev_mode_init_out,
  input wire logic       error_report_mode_out,
  input wire logic [3:0] wdog_scale_halves_out,
  input wire logic [6:0] supply1_threshold_pct_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // ----
  // Enable pin
  // ----
  // Two cycles of mode guard the select-path latency
  a_en_no_fault: assert property (
    error_report_mode_out && $past(error_report_mode_out) &&
    $past(bus_fault_code_in) == 4'h0 |-> en_out)
    else $error("en low without fault");
  a_en_on_fault: assert property (
    error_report_mode_out && $past(error_report_mode_out) &&
    $past(bus_fault_code_in) != 4'h0 |-> !en_out)
    else $error("en high with fault");
  a_en_plain: assert property (
    !error_report_mode_out && !$past(error_report_mode_out) &&
    !$past(reset_in) |-> en_out == $past(en_ctrl_in))
    else $error("en not following control");
  // ----
  // Configuration outputs
  // ----
  a_wd_values: assert property (
    wdog_scale_halves_out inside {4'h2, 4'h3, 4'h5, 4'h7})
    else $error("bad watchdog factor");
  a_th_values: assert property (
    supply1_threshold_pct_out inside {7'h5A, 7'h50, 7'h46})
    else $error("bad threshold");
  a_reset_vals: assert property (
    $fell(reset_in) |-> wdog_scale_halves_out == 4'h2 &&
    supply1_threshold_pct_out == 7'h5A && !sw_dev_mode_init_out &&
    !error_report_mode_out && !en_out)
    else $error("bad values after reset");
  a_cfg_quiet: assert property (
    spi_cs_n_in [*6] |=> $stable(wdog_scale_halves_out) &&
    $stable(supply1_threshold_pct_out) &&
    $stable(sw_dev_mode_init_out) && $stable(error_report_mode_out))
    else $error("config moved while idle");
  a_cfg_framed: assert property (
    $changed(wdog_scale_halves_out) || $changed(sw_dev_mode_init_out)
    |-> $past(spi_cs_n_in, 3))
    else $error("config moved inside frame");
  c_fault: cover property (error_report_mode_out && !en_out);
  c_wd_max: cover property (wdog_scale_halves_out == 4'h7);
  c_sdm: cover property (sw_dev_mode_init_out);
endmodule
bind special_mode_and_user_regs regs_properties chk (
  .clock_in(clock_in), .reset_in(reset_in), .spi_cs_n_in(spi_cs_n_in),
  .bus_fault_code_in(bus_fault_code_in), .en_ctrl_in(en_ctrl_in),
  .en_out(en_out), .sw_dev_mode_init_out(sw_dev_mode_init_out),
  .error_report_mode_out(error_report_mode_out),
  .wdog_scale_halves_out(wdog_scale_halves_out),
  .supply1_threshold_pct_out(supply1_threshold_pct_out));

// File: bench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clock_in,
  output logic      spi_clk_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out,
  input  wire logic spi_miso_in
);
  initial begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  // Wrong bit counts abort; extra bits shift in zero
  task automatic frame(input logic [15:0] tx, input int bits,
                       input int hold, output logic [15:0] rx);
    logic [15:0] sh;
    sh = tx;
    rx = 16'h0000;
    @(negedge clock_in);
    spi_cs_n_out = 1'b0;
    for (int i = 0; i < bits; i++) begin
      spi_mosi_out = sh[15];
      sh = {sh[14:0], 1'b0};
      repeat (hold) @(negedge clock_in);
      if (i < 16) begin
        rx = {rx[14:0], spi_miso_in};
      end
      spi_clk_out = 1'b1;
      repeat (hold) @(negedge clock_in);
      spi_clk_out = 1'b0;
    end
    repeat (hold) @(negedge clock_in);
    spi_cs_n_out = 1'b1;
    // Released line must not keep a stale bit
    spi_mosi_out = ~spi_mosi_out;
    repeat (5) @(negedge clock_in);
  endtask
endmodule

// File: bench/tb_special_mode_and_user_regs.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); \
  end
module tb_special_mode_and_user_regs;
  import sbc_regs_pkg::*;
  // Arbitrary neutral identification value
  localparam logic [10:0] ID  = 11'h3C6;
  localparam logic [11:0] IEN = 12'h1E1;
  localparam logic [11:0] SYS = 12'h2D2;
  localparam logic [11:0] PHY = 12'h4B4;
  logic       clock_in = 1'b0;
  logic       reset_in;
  logic       spi_clk, cs_n, mosi, miso, en_ctrl, en, sdm, err;
  logic [3:0] fault, wd;
  logic [6:0] th;
  int         checks = 0;
  int         bad_count = 0;
  always #5 clock_in = ~clock_in;
  spi_host_model host (.clock_in(clock_in), .spi_clk_out(spi_clk),
    .spi_cs_n_out(cs_n), .spi_mosi_out(mosi), .spi_miso_in(miso));
  special_mode_and_user_regs #(.ID_CODE(ID)) dut (
    .clock_in(clock_in), .reset_in(reset_in), .spi_clk_in(spi_clk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .int_enable_fb_in(IEN), .sys_config_fb_in(SYS),
    .phys_ctrl_fb_in(PHY), .bus_fault_code_in(fault),
    .en_ctrl_in(en_ctrl), .en_out(en), .sw_dev_mode_init_out(sdm),
    .error_report_mode_out(err), .wdog_scale_halves_out(wd),
    .supply1_threshold_pct_out(th));
  // ----
  // Frame helpers
  // ----
  task automatic go(input logic [15:0] tx, output logic [15:0] rx);
    host.frame(tx, 16, 2, rx);
  endtask
  // Reply of a frame only shows during the next one
  task automatic peek(input logic [3:0] hdr, output logic [15:0] rx);
    go({hdr, 12'h000}, rx);
    go(16'h1000, rx);
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_user0;
    logic [15:0] rx;
    go(16'hB000, rx);
    `CHK("first reply", 16'h0000, rx)
    peek(4'hB, rx);
    `CHK("id word", {4'hB, 1'b0, ID}, rx)
    go({4'hA, 12'h2F5}, rx);
    peek(4'hB, rx);
    `CHK("user0", {4'hB, 12'hAF5}, rx)
    go({4'hB, 12'h123}, rx);
    peek(4'hB, rx);
    `CHK("user0 ro", {4'hB, 12'hAF5}, rx)
    peek(4'h9, rx);
    `CHK("sys fb", {4'h9, SYS}, rx)
  endtask
  task automatic t_cfg;
    logic [3:0]  half [4] = '{4'h2, 4'h3, 4'h5, 4'h7};
    logic [6:0]  pct [4]  = '{7'h5A, 7'h50, 7'h46, 7'h5A};
    logic [15:0] rx;
    logic [11:0] d;
    for (int k = 0; k < 4; k++) begin
      d = {2'b00, k[0], 2'b00, k[1:0], k[1:0], 3'b000};
      go({4'h4, d}, rx);
      `CHK("wd", half[k], wd)
      `CHK("thr", pct[k], th)
      `CHK("sdm", k[0], sdm)
      peek(4'h7, rx);
      `CHK("cfg rd", {4'h7, d}, rx)
    end
    peek(4'h5, rx);
    `CHK("ien fb", {4'h5, IEN}, rx)
    go({4'h5, 12'h020}, rx);
    `CHK("wd ro", 4'h7, wd)
  endtask
  task automatic t_en;
    logic [15:0] rx;
    go({4'h4, 12'h100}, rx);
    pause(2);
    `CHK("err", 1'b1, err)
    `CHK("en ok", 1'b1, en)
    fault = 4'h5;
    pause(2);
    `CHK("en fault", 1'b0, en)
    go({4'h4, 12'h000}, rx);
    en_ctrl = 1'b1;
    pause(2);
    `CHK("en ctrl", 1'b1, en)
    en_ctrl = 1'b0;
    pause(2);
    `CHK("en ctrl", 1'b0, en)
  endtask
  task automatic t_abort;
    logic [15:0] rx;
    host.frame({4'h4, 12'h060}, 15, 5, rx);
    `CHK("wd short", 4'h2, wd)
    host.frame({4'h4, 12'h060}, 17, 2, rx);
    `CHK("wd long", 4'h2, wd)
  endtask
  task automatic t_user1;
    logic [15:0] rx;
    go({4'hE, 12'hABC}, rx);
    peek(4'hF, rx);
    `CHK("user1", {4'hF, 12'hABC}, rx)
    peek(4'hD, rx);
    `CHK("phys fb", {4'hD, PHY}, rx)
  endtask
  task automatic end_sim;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    reset_in = 1'b1;
    fault = 4'h0;
    en_ctrl = 1'b0;
    pause(12);
    reset_in = 1'b0;
    t_user0;
    t_cfg;
    t_en;
    t_abort;
    t_user1;
    end_sim;
  end
  initial begin
    repeat (50000) @(posedge clock_in);
    bad_count++;
    end_sim;
  end
endmodule

// File: logic/frame_shifter.sv
`timescale 1ns/1ps
module frame_shifter
  import sbc_regs_pkg::*;
(
  input  wire logic   clock_in,
  input  wire logic   reset_in,
  input  wire logic   spi_clk_in,
  input  wire logic   spi_cs_n_in,
  input  wire logic   spi_mosi_in,
  output logic        spi_miso_out,
  frame_if.shifter    link
);
  import sbc_regs_pkg::*;

  link_state_e             state_r;
  logic                    clk_q_r;
  logic                    cs_q_r;
  logic [COUNT_BITS-1:0]   count_r;
  logic [FRAME_BITS-1:0]   rx_r;
  logic [FRAME_BITS-1:0]   tx_r;
  logic                    done_r;

  wire clk_rise = spi_clk_in & ~clk_q_r;
  wire clk_fall = ~spi_clk_in & clk_q_r;
  wire cs_fall  = cs_q_r & ~spi_cs_n_in;
  wire cs_rise  = ~cs_q_r & spi_cs_n_in;
  wire full     = (count_r == FULL_COUNT);
  // Only an exact 16-bit frame is handed on
  wire good_end = cs_rise & (state_r == LINK_SHIFT) & full;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      clk_q_r <= 1'b0;
      cs_q_r  <= 1'b1;
    end else begin
      clk_q_r <= spi_clk_in;
      cs_q_r  <= spi_cs_n_in;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= LINK_IDLE;
      count_r <= COUNT_ZERO;
    end else if (cs_rise) begin
      state_r <= LINK_IDLE;
    end else if (cs_fall) begin
      state_r <= LINK_SHIFT;
      count_r <= COUNT_ZERO;
    end else if (clk_rise) begin
      unique case (state_r)
        LINK_IDLE:  state_r <= LINK_IDLE;
        LINK_SHIFT: begin
          if (full) begin
            state_r <= LINK_OVER;
          end else begin
            count_r <= count_r + COUNT_ONE;
          end
        end
        LINK_OVER:  state_r <= LINK_OVER;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rx_r <= RESP_RESET;
    end else if (clk_rise && state_r == LINK_SHIFT && !full) begin
      rx_r <= {rx_r[FRAME_BITS-2:0], spi_mosi_in};
    end
  end

  // Reply word is captured at select so a late update cannot tear it
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      tx_r <= RESP_RESET;
    end else if (cs_fall) begin
      tx_r <= link.resp_word;
    end else if (clk_fall && state_r == LINK_SHIFT) begin
      tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      spi_miso_out <= 1'b0;
      done_r       <= 1'b0;
    end else begin
      spi_miso_out <= cs_fall ? link.resp_word[FRAME_BITS-1]
                              : (clk_fall ? tx_r[FRAME_BITS-2]
                                          : spi_miso_out);
      done_r       <= good_end;
    end
  end

  assign link.frame_done = done_r;
  assign link.frame_word = rx_r;
endmodule

// File: logic/special_mode_and_user_regs.sv
`timescale 1ns/1ps
// How it works
// - Address bits 01 select the start-up configuration register.
// - Config frame: select 0 returns interrupt enable, 1 returns config.
// - Read-only flag 1 reads only; 0 reads and stores the data.
// - Bit 9 starts software development mode; clear keeps normal behaviour.
// - Error-report bit set: enable high when fault code 0000, else low.
// - Error-report bit clear: enable output follows ordinary enable control.
// - Bits 6..5 scale watchdog by 1, 1.5, 2.5 or 3.5.
// - Bits 4..3 set reset threshold: 00/11 0.9, 01 0.8, 10 0.7.
// - Two 12-bit user registers, each readable back by the host.
// - After power-up first user register holds the identification code.
// - Address 10 selects user word one; select 1 it, 0 system config.
// - User word one: read-only 1 reads; 0 reads and stores data.
// - User word one bit 11 reads 0 with ID code, 1 after write.
// - User word one bits 10..0 store and return host values.
// - Any write to user word one sets its overwritten bit.
// - Address 11 with select 1 reaches the second user register.
module special_mode_and_user_regs #(
  // Arbitrary neutral identification value
  parameter logic [10:0] ID_CODE = 11'h0A5
) (
  input  wire logic                       clock_in,
  input  wire logic                       reset_in,
  input  wire logic                       spi_clk_in,
  input  wire logic                       spi_cs_n_in,
  input  wire logic                       spi_mosi_in,
  output logic                            spi_miso_out,
  input  wire logic [sbc_regs_pkg::DATA_BITS-1:0] int_enable_fb_in,
  input  wire logic [sbc_regs_pkg::DATA_BITS-1:0] sys_config_fb_in,
  input  wire logic [sbc_regs_pkg::DATA_BITS-1:0] phys_ctrl_fb_in,
  input  wire logic [3:0]                 bus_fault_code_in,
  input  wire logic                       en_ctrl_in,
  output logic                            en_out,
  output logic                            sw_dev_mode_init_out,
  output logic                            error_report_mode_out,
  output logic [3:0]                      wdog_scale_halves_out,
  output logic [6:0]                      supply1_threshold_pct_out
);
  import sbc_regs_pkg::*;

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  frame_if link ();

  frame_shifter u_shifter (
    .clock_in     (clock_in),
    .reset_in     (reset_in),
    .spi_clk_in   (spi_clk_in),
    .spi_cs_n_in  (spi_cs_n_in),
    .spi_mosi_in  (spi_mosi_in),
    .spi_miso_out (spi_miso_out),
    .link         (link)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [DATA_BITS-1:0] config_r;
  logic [DATA_BITS-1:0] user0_r;
  logic [DATA_BITS-1:0] user1_r;
  logic [FRAME_BITS-1:0] resp_r;

  wire [1:0]           reg_select_bits =
    link.frame_word[POS_ADDR_HI:POS_ADDR_LO];
  wire                 readback_select = link.frame_word[POS_RRS];
  wire                 read_only_flag  = link.frame_word[POS_RO];
  wire [DATA_BITS-1:0] wr_data         = link.frame_word[DATA_BITS-1:0];

  wire is_config = (reg_select_bits == ADDR_CONFIG);
  wire is_user0  = (reg_select_bits == ADDR_USER0);
  wire is_phys   = (reg_select_bits == ADDR_PHYS);

  // frame_done only pulses for whole frames
  wire wr_config = link.frame_done & is_config & ~read_only_flag;
  wire wr_user0  = link.frame_done & is_user0 & ~read_only_flag;
  wire wr_user1  = link.frame_done & is_phys & readback_select
                 & ~read_only_flag;

  // ----------------------------------------------------------------
  // Readback selection
  // ----------------------------------------------------------------
  wire [DATA_BITS-1:0] config_fb =
    readback_select ? config_r : int_enable_fb_in;
  wire [DATA_BITS-1:0] user0_fb =
    readback_select ? user0_r : sys_config_fb_in;
  wire [DATA_BITS-1:0] phys_fb =
    readback_select ? user1_r : phys_ctrl_fb_in;
  wire [DATA_BITS-1:0] sel_fb =
    is_config ? config_fb :
    is_user0  ? user0_fb  :
    is_phys   ? phys_fb   : DATA_ZERO;

  // Reply holds the pre-write contents; shifted out in the next frame
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      resp_r <= RESP_RESET;
    end else if (link.frame_done) begin
      resp_r <= {reg_select_bits, readback_select, read_only_flag,
                 sel_fb};
    end
  end

  assign link.resp_word = resp_r;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Reserved positions are dropped, so stray ones never read back
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      config_r <= CONFIG_RESET;
    end else if (wr_config) begin
      config_r <= wr_data & CONFIG_KEEP_MASK;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      user0_r <= {1'b0, ID_CODE};
    end else if (wr_user0) begin
      user0_r <= {1'b1, wr_data[POS_DIC-1:0]};
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      user1_r <= USER1_RESET;
    end else if (wr_user1) begin
      user1_r <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  wire       err_mode = config_r[POS_ERR];
  wire [1:0] wd_sel   = config_r[POS_WD_HI:POS_WD_LO];
  wire [1:0] th_sel   = config_r[POS_TH_HI:POS_TH_LO];
  wire       no_fault = (bus_fault_code_in == FAULT_NONE);

  wire [3:0] wd_halves =
    (wd_sel == 2'h0) ? WD_HALVES_00 :
    (wd_sel == 2'h1) ? WD_HALVES_01 :
    (wd_sel == 2'h2) ? WD_HALVES_10 : WD_HALVES_11;

  wire [6:0] th_pct =
    (th_sel == 2'h1) ? TH_PCT_80 :
    (th_sel == 2'h2) ? TH_PCT_70 : TH_PCT_90;

  wire en_nxt = err_mode ? no_fault : en_ctrl_in;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      en_out                    <= 1'b0;
      sw_dev_mode_init_out      <= 1'b0;
      error_report_mode_out     <= 1'b0;
      wdog_scale_halves_out     <= WD_HALVES_00;
      supply1_threshold_pct_out <= TH_PCT_90;
    end else begin
      en_out                    <= en_nxt;
      sw_dev_mode_init_out      <= config_r[POS_SDM];
      error_report_mode_out     <= err_mode;
      wdog_scale_halves_out     <= wd_halves;
      supply1_threshold_pct_out <= th_pct;
    end
  end
endmodule

// File: shared/frame_if.sv
`timescale 1ns/1ps
interface frame_if;
  logic        frame_done;
  logic [15:0] frame_word;
  logic [15:0] resp_word;

  modport shifter (
    output frame_done,
    output frame_word,
    input  resp_word
  );
  modport bank (
    input  frame_done,
    input  frame_word,
    output resp_word
  );
endinterface

// File: shared/sbc_regs_pkg.sv
package sbc_regs_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS  = 16;
  localparam int DATA_BITS   = 12;
  localparam int COUNT_BITS  = 5;
  localparam int POS_ADDR_HI = 15;
  localparam int POS_ADDR_LO = 14;
  localparam int POS_RRS     = 13;
  localparam int POS_RO      = 12;

  localparam logic [1:0] ADDR_OTHER  = 2'h0;
  localparam logic [1:0] ADDR_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_USER0  = 2'h2;
  localparam logic [1:0] ADDR_PHYS   = 2'h3;

  localparam logic [COUNT_BITS-1:0] FULL_COUNT = 5'h10;
  localparam logic [COUNT_BITS-1:0] COUNT_ONE  = 5'h01;
  localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Start-up configuration fields
  // ----------------------------------------------------------------
  localparam int POS_SDM   = 9;
  localparam int POS_ERR   = 8;
  localparam int POS_WD_HI = 6;
  localparam int POS_WD_LO = 5;
  localparam int POS_TH_HI = 4;
  localparam int POS_TH_LO = 3;
  localparam int POS_DIC   = 11;

  // Bits 11, 10, 7, 2..0 are not stored and read as zero
  localparam logic [11:0] CONFIG_KEEP_MASK = 12'h378;
  localparam logic [11:0] CONFIG_RESET     = 12'h000;
  localparam logic [11:0] USER1_RESET      = 12'h000;
  localparam logic [15:0] RESP_RESET       = 16'h0000;
  localparam logic [11:0] DATA_ZERO        = 12'h000;

  // Watchdog scale in half steps: 1, 1.5, 2.5, 3.5
  localparam logic [3:0] WD_HALVES_00 = 4'h2;
  localparam logic [3:0] WD_HALVES_01 = 4'h3;
  localparam logic [3:0] WD_HALVES_10 = 4'h5;
  localparam logic [3:0] WD_HALVES_11 = 4'h7;

  // Reset threshold in percent of nominal supply
  localparam logic [6:0] TH_PCT_90 = 7'h5A;
  localparam logic [6:0] TH_PCT_80 = 7'h50;
  localparam logic [6:0] TH_PCT_70 = 7'h46;

  localparam logic [3:0] FAULT_NONE = 4'h0;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_OVER  = 2'b10
  } link_state_e;

endpackage
